// ===== rtl/ris_status_word.sv
// Reader-side event and status word with request gating
// Behaviour
// - Bit 12 high while tamper pin is off ground, low when grounded.
// - Bit 7 sets when latest converter code crosses threshold level or window.
// - Threshold flag enabled only with bits 8..10 of all three sensor configs.
// - Threshold flag clears when a new sensor conversion is requested.
// - Bit 6 sets when wake-up countdown ends; enabled by timer config bit 0.
// - Wake-up flag clears when timer starts a new phase in auto logging.
// - Bit 5 sets when logger finishes last transfer in non-loop mode; bit 2 enable.
// - Reading the status word clears the transfer done flag.
// - Bit 4 sets when looped logging fills memory; logging keeps overwriting.
// - Wrap flag needs logger config bits 2 and 3; clears when logging stops.
// - Bit 2 sets on failed command; cleared by reset or status read.
// - Bit 1 high while a core request is outstanding, low when done.
// - New requests ignored while pending; reader should wait for bit 1 low.
// - Bit 0 high while core moves data; reader requests refused meanwhile.
// - Word read-only at device address 0x01; writes have no effect.
// - Core lock blocks new logger transactions without aborting a running one.
`timescale 1ns/1ps
`include "ris_defines.svh"
module ris_status_word
  import ris_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic                      tamper_detect_pin,
  input  wire logic                      dev_rd_req,
  input  wire logic                      dev_wr_req,
  input  wire logic [`RIS_ADDR_W-1:0]    dev_addr,
  input  wire logic [`RIS_WORD_W-1:0]    dev_wr_data,
  input  wire logic                      core_req,
  input  wire logic                      core_done,
  input  wire logic                      core_busy,
  input  wire logic [`RIS_WORD_W-1:0]    sens_cfg_a,
  input  wire logic [`RIS_WORD_W-1:0]    sens_cfg_b,
  input  wire logic [`RIS_WORD_W-1:0]    sens_cfg_c,
  input  wire logic                      adc_cross,
  input  wire logic                      conv_req,
  input  wire logic [`RIS_WORD_W-1:0]    timer_cfg,
  input  wire logic                      wakeup_done,
  input  wire logic                      timer_restart,
  input  wire logic [`RIS_WORD_W-1:0]    log_cfg,
  input  wire logic                      log_xfer_done,
  input  wire logic                      log_mem_full,
  input  wire logic                      log_stop,
  input  wire logic                      cmd_fail,
  input  wire logic [`RIS_WORD_W-1:0]    core_ctrl,
  input  wire logic                      log_req,
  input  wire logic                      log_active,
  output logic [`RIS_WORD_W-1:0]         rd_data_q,
  output logic                           rd_valid_q,
  output logic                           core_go_q,
  output logic                           req_refused_q,
  output logic                           log_grant_q
);
  logic           external_event_flag;
  logic           thr_flag_q;
  logic           wakeup_timer_flag_q;
  logic           xfer_flag_q;
  logic           wrap_flag_q;
  logic           fail_flag_q;
  ris_req_state_t req_state_q;
  logic           thr_en;
  logic           wake_en;
  logic           xfer_en;
  logic           wrap_en;
  logic           status_rd;
  logic           req_ok;
  logic [`RIS_WORD_W-1:0] status_word;

  ris_sync3 u_tamper_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (tamper_detect_pin),
    .level_q  (external_event_flag)
  );

  assign thr_en    = ((sens_cfg_a & sens_cfg_b & sens_cfg_c & `RIS_THR_MASK) == `RIS_THR_MASK);
  assign wake_en   = timer_cfg[`RIS_WAKE_EN_BIT];
  assign xfer_en   = log_cfg[`RIS_XFER_EN_BIT];
  assign wrap_en   = ((log_cfg & `RIS_WRAP_EN_MASK) == `RIS_WRAP_EN_MASK);
  // Writes at this address are deliberately not decoded
  assign status_rd = dev_rd_req && (dev_addr == `RIS_STATUS_ADDR);
  // Polling the status word stays possible while requests are refused
  assign req_ok    = (req_state_q == RIS_REQ_IDLE) && !core_busy;

  always_comb begin
    status_word                 = `RIS_STATUS_RST;
    status_word[`RIS_BIT_EXT]   = external_event_flag;
    status_word[`RIS_BIT_THR]   = thr_flag_q;
    status_word[`RIS_BIT_WAKE]  = wakeup_timer_flag_q;
    status_word[`RIS_BIT_XFER]  = xfer_flag_q;
    status_word[`RIS_BIT_WRAP]  = wrap_flag_q;
    status_word[`RIS_BIT_FAIL]  = fail_flag_q;
    status_word[`RIS_BIT_PEND]  = (req_state_q == RIS_REQ_PEND);
    status_word[`RIS_BIT_BUSY]  = core_busy;
  end

  // In every flag below a set in the same cycle as its clear wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      thr_flag_q <= 1'b0;
    end else if (adc_cross && thr_en) begin
      thr_flag_q <= 1'b1;
    end else if (conv_req) begin
      thr_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wakeup_timer_flag_q <= 1'b0;
    end else if (wakeup_done && wake_en) begin
      wakeup_timer_flag_q <= 1'b1;
    end else if (timer_restart) begin
      wakeup_timer_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xfer_flag_q <= 1'b0;
    end else if (log_xfer_done && xfer_en) begin
      xfer_flag_q <= 1'b1;
    end else if (status_rd) begin
      xfer_flag_q <= 1'b0;
    end
  end

  // Overwriting the oldest samples is the logger's job; only the event is kept here
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrap_flag_q <= 1'b0;
    end else if (log_mem_full && wrap_en) begin
      wrap_flag_q <= 1'b1;
    end else if (log_stop) begin
      wrap_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fail_flag_q <= 1'b0;
    end else if (cmd_fail) begin
      fail_flag_q <= 1'b1;
    end else if (status_rd) begin
      fail_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_state_q <= RIS_REQ_IDLE;
    end else begin
      case (req_state_q)
        RIS_REQ_IDLE: begin
          if (core_req && req_ok) begin
            req_state_q <= RIS_REQ_PEND;
          end
        end
        RIS_REQ_PEND: begin
          if (core_done) begin
            req_state_q <= RIS_REQ_IDLE;
          end
        end
        default: begin
          req_state_q <= RIS_REQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_go_q     <= 1'b0;
      req_refused_q <= 1'b0;
    end else begin
      core_go_q     <= core_req && req_ok;
      req_refused_q <= core_req && !req_ok;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_q  <= `RIS_STATUS_RST;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= status_rd;
      if (status_rd) begin
        rd_data_q <= status_word;
      end
    end
  end

  // A transaction already running keeps its grant when the lock arrives
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      log_grant_q <= 1'b0;
    end else begin
      log_grant_q <= log_req && (!core_ctrl[`RIS_LOCK_BIT] || log_active);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_read_answer;
    status_rd |=> rd_valid_q && rd_data_q[`RIS_BIT_BUSY] == $past(core_busy);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("status read not answered");

  property p_reserved_zero;
    rd_valid_q |-> ((rd_data_q & ~`RIS_USED_MASK) == `RIS_STATUS_RST);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_thr_set;
    adc_cross && thr_en |=> thr_flag_q;
  endproperty
  a_thr_set: assert property (p_thr_set) else $error("threshold flag not set");

  property p_thr_gate;
    !thr_flag_q && ((sens_cfg_a & sens_cfg_b & sens_cfg_c & `RIS_THR_MASK) != `RIS_THR_MASK) |=> !thr_flag_q;
  endproperty
  a_thr_gate: assert property (p_thr_gate) else $error("threshold flag set while disabled");

  property p_thr_clear;
    conv_req && !adc_cross |=> !thr_flag_q;
  endproperty
  a_thr_clear: assert property (p_thr_clear) else $error("threshold flag not cleared");

  property p_wake;
    (wakeup_done && wake_en) ##1 !timer_restart [*2] |-> wakeup_timer_flag_q;
  endproperty
  a_wake: assert property (p_wake) else $error("wake flag lost");

  property p_wake_clear;
    timer_restart && !wakeup_done |=> !wakeup_timer_flag_q;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake flag not cleared");

  property p_xfer_read_clear;
    status_rd && !log_xfer_done |=> !xfer_flag_q && !$past(cmd_fail) == !fail_flag_q;
  endproperty
  a_xfer_read_clear: assert property (p_xfer_read_clear) else $error("read did not clear flags");

  property p_xfer_set;
    log_xfer_done && xfer_en |=> xfer_flag_q;
  endproperty
  a_xfer_set: assert property (p_xfer_set) else $error("transfer flag not set");

  property p_wrap;
    log_mem_full && ((log_cfg & `RIS_WRAP_EN_MASK) != `RIS_WRAP_EN_MASK) && !wrap_flag_q |=> !wrap_flag_q;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag set while disabled");

  property p_fail;
    cmd_fail |=> fail_flag_q;
  endproperty
  a_fail: assert property (p_fail) else $error("fail flag not set");

  property p_pend_refuse;
    (req_state_q == RIS_REQ_PEND || core_busy) && core_req |=> req_refused_q && !core_go_q;
  endproperty
  a_pend_refuse: assert property (p_pend_refuse) else $error("request not refused");

  property p_pend_hold;
    core_go_q |-> (req_state_q == RIS_REQ_PEND);
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending not raised");

  property p_lock;
    log_req && core_ctrl[`RIS_LOCK_BIT] && !log_active |=> !log_grant_q;
  endproperty
  a_lock: assert property (p_lock) else $error("logger granted under lock");

  property p_write_ignored;
    dev_wr_req && !dev_rd_req |=> !rd_valid_q && $stable(rd_data_q);
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("write changed the status answer");

  c_read:    cover property (status_rd ##1 rd_valid_q);
  c_refused: cover property (req_refused_q);
  c_wrap:    cover property (wrap_flag_q ##1 log_stop ##1 !wrap_flag_q);
endmodule

// ===== rtl/ris_defines.svh
// Constant names for the reader event and status word block
`ifndef RIS_DEFINES_SVH
`define RIS_DEFINES_SVH
`define RIS_ADDR_W          8
`define RIS_WORD_W          16
`define RIS_STATUS_ADDR     8'h01
`define RIS_STATUS_RST      16'h0000
`define RIS_USED_MASK       16'h10f7
`define RIS_BIT_EXT         12
`define RIS_BIT_THR         7
`define RIS_BIT_WAKE        6
`define RIS_BIT_XFER        5
`define RIS_BIT_WRAP        4
`define RIS_BIT_FAIL        2
`define RIS_BIT_PEND        1
`define RIS_BIT_BUSY        0
`define RIS_THR_EN_BIT      8
`define RIS_THR_MASK        16'h0700
`define RIS_WAKE_EN_BIT     0
`define RIS_XFER_EN_BIT     2
`define RIS_WRAP_EN_MASK    16'h000c
`define RIS_LOCK_BIT        0
`endif

// ===== rtl/ris_pkg.sv
// Types shared by the reader event and status word block
package ris_pkg;
  typedef enum logic [1:0] {
    RIS_REQ_IDLE = 2'b01,
    RIS_REQ_PEND = 2'b10
  } ris_req_state_t;
endpackage

// ===== rtl/ris_sync3.sv
// Three-stage synchroniser with agreement filter for one level
`timescale 1ns/1ps
module ris_sync3 (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Only the two settled stages vote; the first stage may be metastable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end
endmodule

// ===== dv/ris_reader_model.sv
// Reader model: status reads, device writes and core requests
`timescale 1ns/1ps
module ris_reader_model (
  input  wire logic        clk,
  input  wire logic [15:0] rd_data_q,
  input  wire logic        rd_valid_q,
  input  wire logic        core_go_q,
  input  wire logic        req_refused_q,
  output logic             dev_rd_req,
  output logic             dev_wr_req,
  output logic [7:0]       dev_addr,
  output logic [15:0]      dev_wr_data,
  output logic             core_req
);
  initial begin
    dev_rd_req = 1'b0;
    dev_wr_req = 1'b0;
    dev_addr = 8'hfe;
    dev_wr_data = 16'h5a5a;
    core_req = 1'b0;
  end
  // Released lines carry the inverse so a stale address cannot pass as valid
  task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] wd,
                        output logic vld, output logic [15:0] word);
    @(posedge clk);
    #2;
    dev_rd_req = !wr;
    dev_wr_req = wr;
    dev_addr = addr;
    dev_wr_data = wd;
    @(posedge clk);
    #2;
    dev_rd_req = 1'b0;
    dev_wr_req = 1'b0;
    dev_addr = ~addr;
    dev_wr_data = ~wd;
    vld = rd_valid_q;
    word = rd_data_q;
  endtask
  // A polite reader polls the pending bit first; an impatient one does not
  task automatic core_request(input logic polite, output logic go, output logic refused);
    logic        v;
    logic [15:0] w;
    w = 16'h0002;
    while (polite && w[1] !== 1'b0) access(1'b0, 8'h01, 16'h0000, v, w);
    @(posedge clk);
    #2;
    core_req = 1'b1;
    @(posedge clk);
    #2;
    core_req = 1'b0;
    go = core_go_q;
    refused = req_refused_q;
  endtask
endmodule

// ===== dv/tb_rfid_irq_status_word.sv
// Testbench for the reader event and status word
`timescale 1ns/1ps
module tb_rfid_irq_status_word;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        tamper = 1'b0;
  logic        core_busy = 1'b0;
  logic        log_req = 1'b0;
  logic        log_active = 1'b0;
  logic [8:0]  ev = 9'h000;
  logic [15:0] cfg_a = 16'h0700;
  logic [15:0] cfg_b = 16'h0700;
  logic [15:0] cfg_c = 16'h0700;
  logic [15:0] timer_cfg = 16'h0001;
  logic [15:0] log_cfg = 16'h000c;
  logic [15:0] core_ctrl = 16'h0000;
  logic        rd_req, wr_req, core_req, rd_valid, go_q, ref_q, grant;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, w;
  logic        v, go, rf;
  int          num_errors = 0;
  int          samples_checked = 0;
  always #10 clk = ~clk;
  ris_status_word dut_u (.clk(clk), .sys_rst(sys_rst), .tamper_detect_pin(tamper),
    .dev_rd_req(rd_req), .dev_wr_req(wr_req), .dev_addr(addr), .dev_wr_data(wdata),
    .core_req(core_req), .core_done(ev[8]), .core_busy(core_busy), .sens_cfg_a(cfg_a),
    .sens_cfg_b(cfg_b), .sens_cfg_c(cfg_c), .adc_cross(ev[0]), .conv_req(ev[1]),
    .timer_cfg(timer_cfg), .wakeup_done(ev[2]), .timer_restart(ev[3]), .log_cfg(log_cfg),
    .log_xfer_done(ev[4]), .log_mem_full(ev[5]), .log_stop(ev[6]), .cmd_fail(ev[7]),
    .core_ctrl(core_ctrl), .log_req(log_req), .log_active(log_active), .rd_data_q(rdata),
    .rd_valid_q(rd_valid), .core_go_q(go_q), .req_refused_q(ref_q), .log_grant_q(grant));
  ris_reader_model rdr_u (.clk(clk), .rd_data_q(rdata), .rd_valid_q(rd_valid),
    .core_go_q(go_q), .req_refused_q(ref_q), .dev_rd_req(rd_req), .dev_wr_req(wr_req),
    .dev_addr(addr), .dev_wr_data(wdata), .core_req(core_req));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [15:0] exp);
    rdr_u.access(1'b0, 8'h01, 16'h0000, v, w);
    check({15'h0000, v}, 16'h0001);
    check(w, exp);
  endtask
  task automatic pulse(input logic [8:0] mask);
    @(posedge clk);
    #2 ev = mask;
    @(posedge clk);
    #2 ev = 9'h000;
  endtask
  task automatic complete_run;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge clk);
    #2 sys_rst = 1'b0;
    rd(16'h0000);
    tamper = 1'b1;
    repeat (6) @(posedge clk);
    rd(16'h1000);
    pulse(9'h0b5);
    rd(16'h10f4);
    rd(16'h10d0);
    rdr_u.access(1'b1, 8'h01, 16'hffff, v, w);
    check({15'h0000, v}, 16'h0000);
    rdr_u.access(1'b0, 8'h02, 16'h0000, v, w);
    check({15'h0000, v}, 16'h0000);
    rd(16'h10d0);
    pulse(9'h04a);
    rd(16'h1000);
    // One sensor config short of the full mask must keep the threshold flag off
    cfg_b = 16'h0300;
    timer_cfg = 16'h0000;
    log_cfg = 16'h0008;
    pulse(9'h035);
    rd(16'h1000);
    cfg_b = 16'h0700;
    cfg_a = 16'h0600;
    pulse(9'h001);
    rd(16'h1000);
    cfg_a = 16'h0700;
    cfg_c = 16'h0300;
    pulse(9'h001);
    rd(16'h1000);
    cfg_c = 16'h0700;
    // A crossing in the same cycle as a conversion request must win
    pulse(9'h003);
    rd(16'h1080);
    pulse(9'h002);
    rd(16'h1000);
    rdr_u.core_request(1'b1, go, rf);
    check({14'h0000, go, rf}, 16'h0002);
    rd(16'h1002);
    rdr_u.core_request(1'b0, go, rf);
    check({14'h0000, go, rf}, 16'h0001);
    pulse(9'h100);
    rd(16'h1000);
    core_busy = 1'b1;
    rd(16'h1001);
    rdr_u.core_request(1'b0, go, rf);
    check({14'h0000, go, rf}, 16'h0001);
    core_busy = 1'b0;
    core_ctrl = 16'h0001;
    log_req = 1'b1;
    @(posedge clk);
    #2 check({15'h0000, grant}, 16'h0000);
    log_active = 1'b1;
    @(posedge clk);
    #2 check({15'h0000, grant}, 16'h0001);
    core_ctrl = 16'h0000;
    log_active = 1'b0;
    @(posedge clk);
    #2 check({15'h0000, grant}, 16'h0001);
    tamper = 1'b0;
    repeat (6) @(posedge clk);
    rd(16'h0000);
    complete_run;
  end
endmodule
